// *** status_event_register_groups.sv ***
// Fault, operation and standard event status register groups
`timescale 1ns/10ps
`default_nettype none

//Contract
// [R1] Condition registers track live signals unlatched
// [R2] Host writes enables; enable permits recording
// [R3] Event bit captures condition only when enabled
// [R4] Event bits hold until read, read clears
// [R5] Repeated toggling records a single event
// [R6] Fault bit follows fault presence exactly
// [R7] Fault low byte bit assignment
// [R8] Fault high byte bit assignment
// [R9] Operation low byte bit assignment
// [R10] Operation high byte bit assignment
// [R11] Standard event status bit assignment
// [R12] Standard event status read clears it
// [R13] Power-on clear setting empties standard enable
// [R14] Operation done set when command finished
// [R15] Command and run error ranges set bits
// [R16] Device and query error ranges set bits
// [R17] Power-up event set once at start
// [R18] Watchdog expiry sets fault 15, shuts output
// [R19] Unassigned bits read zero, ignore writes
module status_event_register_groups
	import status_regs_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Fault sources, asynchronous levels
	input wire logic mains_fail,
	input wire logic over_temperature,
	input wire logic foldback_fault,
	input wire logic overvoltage_fault,
	input wire logic daisy_shutoff,
	input wire logic output_off,
	input wire logic interlock_fault,
	input wire logic external_enable_fault,
	input wire logic undervoltage_protect,
	input wire logic parallel_acknowledge,
	input wire logic general_fault,
	input wire logic parallel_fault,
	input wire logic parallel_wait_for_follower,
	input wire logic power_switch_off_fault,
	// Operation status sources, asynchronous levels
	input wire logic voltage_regulation_mode,
	input wire logic current_regulation_mode,
	input wire logic no_fault_flag,
	input wire logic trigger_wait_flag,
	input wire logic auto_power_up_flag,
	input wire logic foldback_armed,
	input wire logic sequencer_step_flag,
	input wire logic front_panel_control_flag,
	input wire logic undervoltage_protect_armed,
	input wire logic interlock_control_active,
	input wire logic enable_control_active,
	input wire logic current_foldback_armed,
	input wire logic external_voltage_ref,
	input wire logic external_current_ref,
	input wire logic power_limit_armed,
	input wire logic power_regulation_mode,
	// Link watchdog, same clock domain
	input wire logic link_watchdog_expired,
	input wire logic watchdog_enabled,
	input wire logic protection_clear,
	output logic output_shutdown,
	// Command parser events, same clock domain
	input wire logic command_finished,
	input wire logic error_valid,
	input wire logic signed [15:0] error_code,
	// Stored settings sampled after reset release
	input wire logic power_on_clear_flag,
	input wire logic [7:0] saved_standard_enable,
	// Host register access
	input wire logic cmd_write,
	input wire logic cmd_read,
	input wire logic [2:0] cmd_sel,
	input wire logic [15:0] cmd_wdata,
	output logic [15:0] rd_data,
	output logic rd_valid
);

	typedef struct packed {
		logic [15:0] fault_sync1;
		logic [15:0] fault_sync2;
		logic [15:0] oper_sync1;
		logic [15:0] oper_sync2;
		logic watchdog_fault;
		start_state_t start;
		logic [7:0] standard_event_status;
		logic [7:0] standard_event_enable;
		logic [15:0] rd_data;
		logic rd_valid;
	} top_state_t;

	top_state_t state;
	top_state_t next_state;

	logic [15:0] fault_raw;
	logic [15:0] oper_raw;
	logic [15:0] fault_condition;
	logic [15:0] operation_condition;
	logic [15:0] fault_enable;
	logic [15:0] fault_event;
	logic [15:0] operation_enable;
	logic [15:0] operation_event;
	logic fault_enable_write;
	logic fault_event_read;
	logic oper_enable_write;
	logic oper_event_read;
	logic [7:0] error_bits;

	// Gather fault pins; bit 0 has no source
	always_comb begin
		fault_raw = RESET_WORD;
		fault_raw[FAULT_MAINS_FAIL] = mains_fail; // [R7]
		fault_raw[FAULT_OVER_TEMPERATURE] = over_temperature; // [R7]
		fault_raw[FAULT_FOLDBACK] = foldback_fault; // [R7]
		fault_raw[FAULT_OVERVOLTAGE] = overvoltage_fault; // [R7]
		fault_raw[FAULT_DAISY_SHUTOFF] = daisy_shutoff; // [R7]
		fault_raw[FAULT_OUTPUT_OFF] = output_off; // [R7]
		fault_raw[FAULT_INTERLOCK] = interlock_fault; // [R7]
		fault_raw[FAULT_EXTERNAL_ENABLE] = external_enable_fault; // [R8]
		fault_raw[FAULT_UNDERVOLTAGE] = undervoltage_protect; // [R8]
		fault_raw[FAULT_PARALLEL_ACK] = parallel_acknowledge; // [R8]
		fault_raw[FAULT_GENERAL] = general_fault; // [R8]
		fault_raw[FAULT_PARALLEL] = parallel_fault; // [R8]
		fault_raw[FAULT_PARALLEL_WAIT] = parallel_wait_for_follower; // [R8]
		fault_raw[FAULT_POWER_SWITCH_OFF] = power_switch_off_fault; // [R8]
	end

	// Gather operation status pins, bit 15 downward
	assign oper_raw = {
		power_regulation_mode, // [R10]
		power_limit_armed,
		external_current_ref,
		external_voltage_ref,
		current_foldback_armed,
		enable_control_active,
		interlock_control_active,
		undervoltage_protect_armed,
		front_panel_control_flag, // [R9]
		sequencer_step_flag,
		foldback_armed,
		auto_power_up_flag,
		trigger_wait_flag,
		no_fault_flag,
		current_regulation_mode,
		voltage_regulation_mode
	};

	// Snapshot of synced pins, no latching, two flops of lag; fault bit 15 is the held watchdog flop, one flop from expiry
	always_comb begin
		fault_condition = state.fault_sync2 & FAULT_VALID_MASK; // [R1] [R6] [R19]
		fault_condition[FAULT_LINK_WATCHDOG] = state.watchdog_fault; // [R18]
		operation_condition = state.oper_sync2; // [R1]
	end

	// Host strobes decoded per group
	assign fault_enable_write = cmd_write && (cmd_sel == SEL_FAULT_ENABLE);
	assign fault_event_read = cmd_read && (cmd_sel == SEL_FAULT_EVENT);
	assign oper_enable_write = cmd_write && (cmd_sel == SEL_OPERATION_ENABLE);
	assign oper_event_read = cmd_read && (cmd_sel == SEL_OPERATION_EVENT);

	event_group #(
		.WIDTH(16),
		.VALID_MASK(FAULT_VALID_MASK)
	) fault_group (
		.clock(clock),
		.rst_n(rst_n),
		.condition(fault_condition),
		.enable_write(fault_enable_write),
		.enable_wdata(cmd_wdata),
		.event_read(fault_event_read),
		.enable(fault_enable),
		.event_bits(fault_event)
	);

	event_group #(
		.WIDTH(16),
		.VALID_MASK(OPERATION_VALID_MASK)
	) operation_group (
		.clock(clock),
		.rst_n(rst_n),
		.condition(operation_condition),
		.enable_write(oper_enable_write),
		.enable_wdata(cmd_wdata),
		.event_read(oper_event_read),
		.enable(operation_enable),
		.event_bits(operation_event)
	);

	// Error code classes into standard event bits
	always_comb begin
		error_bits = RESET_BYTE;
		if (error_valid) begin
			if (error_code <= CMD_ERR_HIGH && error_code >= CMD_ERR_LOW) begin
				error_bits[STD_COMMAND_ERROR] = 1'b1; // [R15]
			end
			if (error_code <= RUN_ERR_HIGH && error_code >= RUN_ERR_LOW) begin
				error_bits[STD_RUN_FAILURE_ERROR] = 1'b1; // [R15]
			end
			if ((error_code <= DEV_ERR_HIGH && error_code >= DEV_ERR_LOW)
				|| (error_code >= DEV_POS_LOW && error_code <= DEV_POS_HIGH)) begin
				error_bits[STD_DEVICE_SPECIFIC_ERROR] = 1'b1; // [R16]
			end
			if (error_code <= QUERY_ERR_HIGH && error_code >= QUERY_ERR_LOW) begin
				error_bits[STD_QUERY_ERROR] = 1'b1; // [R16]
			end
		end
		if (command_finished) begin
			error_bits[STD_OPERATION_DONE] = 1'b1; // [R14]
		end
	end

	// Main next-state logic
	always_comb begin
		next_state = state;

		// Two flops before any logic looks at a pin
		next_state.fault_sync1 = fault_raw;
		next_state.fault_sync2 = state.fault_sync1;
		next_state.oper_sync1 = oper_raw;
		next_state.oper_sync2 = state.oper_sync1;

		// Watchdog fault holds until cleared; expiry wins over the clear
		if (protection_clear || !watchdog_enabled) begin
			next_state.watchdog_fault = 1'b0;
		end
		if (link_watchdog_expired && watchdog_enabled) begin
			next_state.watchdog_fault = 1'b1; // [R18]
		end

		// Standard event status: read clears, new events still land
		if (cmd_read && cmd_sel == SEL_STANDARD_EVENT_STATUS) begin
			next_state.standard_event_status = RESET_BYTE; // [R12]
		end
		next_state.standard_event_status = next_state.standard_event_status
			| (error_bits & STANDARD_VALID_MASK); // [R11] [R19]

		if (cmd_write && cmd_sel == SEL_STANDARD_EVENT_ENABLE) begin
			next_state.standard_event_enable = cmd_wdata[7:0] & STANDARD_VALID_MASK; // [R2] [R19]
		end

		// Stored settings are sampled two clocks after reset release
		case (state.start)
			START_IDLE: begin
				next_state.start = START_LOAD;
			end
			START_LOAD: begin
				next_state.start = START_RUN;
				next_state.standard_event_status[STD_POWER_UP_EVENT] = 1'b1; // [R17]
				if (power_on_clear_flag) begin
					next_state.standard_event_enable = RESET_BYTE; // [R13]
				end else begin
					next_state.standard_event_enable =
						saved_standard_enable & STANDARD_VALID_MASK; // [R13]
				end
			end
			START_RUN: begin
				next_state.start = START_RUN;
			end
			default: begin
				next_state.start = START_IDLE;
			end
		endcase

		// Read data comes from a flop, one cycle after the strobe
		next_state.rd_valid = cmd_read;
		if (cmd_read) begin
			case (cmd_sel)
				SEL_FAULT_CONDITION: next_state.rd_data = fault_condition;
				SEL_FAULT_EVENT: next_state.rd_data = fault_event; // [R4]
				SEL_FAULT_ENABLE: next_state.rd_data = fault_enable;
				SEL_OPERATION_CONDITION: next_state.rd_data = operation_condition;
				SEL_OPERATION_EVENT: next_state.rd_data = operation_event; // [R4]
				SEL_OPERATION_ENABLE: next_state.rd_data = operation_enable;
				SEL_STANDARD_EVENT_STATUS: begin
					next_state.rd_data = {8'h00, state.standard_event_status}; // [R12]
				end
				SEL_STANDARD_EVENT_ENABLE: begin
					next_state.rd_data = {8'h00, state.standard_event_enable};
				end
				default: next_state.rd_data = RESET_WORD;
			endcase
		end
	end

	// Single state register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign output_shutdown = state.watchdog_fault; // [R18]
	assign rd_data = state.rd_data;
	assign rd_valid = state.rd_valid;

endmodule

`default_nettype wire

// *** status_regs_pkg.sv ***
// Constants shared by the status and event register groups
package status_regs_pkg;

	// Register selects on the command port
	localparam logic [2:0] SEL_FAULT_CONDITION = 3'h0;
	localparam logic [2:0] SEL_FAULT_EVENT = 3'h1;
	localparam logic [2:0] SEL_FAULT_ENABLE = 3'h2;
	localparam logic [2:0] SEL_OPERATION_CONDITION = 3'h3;
	localparam logic [2:0] SEL_OPERATION_EVENT = 3'h4;
	localparam logic [2:0] SEL_OPERATION_ENABLE = 3'h5;
	localparam logic [2:0] SEL_STANDARD_EVENT_STATUS = 3'h6;
	localparam logic [2:0] SEL_STANDARD_EVENT_ENABLE = 3'h7;

	// Fault condition bit positions
	localparam int FAULT_MAINS_FAIL = 1;
	localparam int FAULT_OVER_TEMPERATURE = 2;
	localparam int FAULT_FOLDBACK = 3;
	localparam int FAULT_OVERVOLTAGE = 4;
	localparam int FAULT_DAISY_SHUTOFF = 5;
	localparam int FAULT_OUTPUT_OFF = 6;
	localparam int FAULT_INTERLOCK = 7;
	localparam int FAULT_EXTERNAL_ENABLE = 8;
	localparam int FAULT_UNDERVOLTAGE = 9;
	localparam int FAULT_PARALLEL_ACK = 10;
	localparam int FAULT_GENERAL = 11;
	localparam int FAULT_PARALLEL = 12;
	localparam int FAULT_PARALLEL_WAIT = 13;
	localparam int FAULT_POWER_SWITCH_OFF = 14;
	localparam int FAULT_LINK_WATCHDOG = 15;

	// Usable bits per register, the rest read zero
	localparam logic [15:0] FAULT_VALID_MASK = 16'hfffe;
	localparam logic [15:0] OPERATION_VALID_MASK = 16'hffff;
	localparam logic [7:0] STANDARD_VALID_MASK = 8'hbd;

	// Standard event status bit positions
	localparam int STD_OPERATION_DONE = 0;
	localparam int STD_QUERY_ERROR = 2;
	localparam int STD_DEVICE_SPECIFIC_ERROR = 3;
	localparam int STD_RUN_FAILURE_ERROR = 4;
	localparam int STD_COMMAND_ERROR = 5;
	localparam int STD_POWER_UP_EVENT = 7;

	// Error code ranges
	localparam logic signed [15:0] CMD_ERR_HIGH = -16'sd100;
	localparam logic signed [15:0] CMD_ERR_LOW = -16'sd199;
	localparam logic signed [15:0] RUN_ERR_HIGH = -16'sd200;
	localparam logic signed [15:0] RUN_ERR_LOW = -16'sd299;
	localparam logic signed [15:0] DEV_ERR_HIGH = -16'sd300;
	localparam logic signed [15:0] DEV_ERR_LOW = -16'sd399;
	localparam logic signed [15:0] DEV_POS_LOW = 16'sd1;
	localparam logic signed [15:0] DEV_POS_HIGH = 16'sd32762;
	localparam logic signed [15:0] QUERY_ERR_HIGH = -16'sd400;
	localparam logic signed [15:0] QUERY_ERR_LOW = -16'sd499;

	// Reset values
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// Start-up sequence after reset release
	typedef enum logic [1:0] {
		START_IDLE = 2'b00,
		START_LOAD = 2'b01,
		START_RUN = 2'b11
	} start_state_t;

endpackage

// *** event_group.sv ***
// One condition, enable and latched event register group
`timescale 1ns/10ps
`default_nettype none

module event_group
	import status_regs_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] VALID_MASK = '1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Live condition snapshot
	input wire logic [WIDTH-1:0] condition,
	// Host access
	input wire logic enable_write,
	input wire logic [WIDTH-1:0] enable_wdata,
	input wire logic event_read,
	// Register contents
	output logic [WIDTH-1:0] enable,
	output logic [WIDTH-1:0] event_bits
);

	typedef struct packed {
		logic [WIDTH-1:0] enable;
		logic [WIDTH-1:0] event_bits;
	} group_state_t;

	group_state_t state;
	group_state_t next_state;

	// Capture is level based, so toggling between reads only keeps the bit set
	always_comb begin
		next_state = state;
		if (enable_write) begin
			next_state.enable = enable_wdata & VALID_MASK; // [R2] [R19]
		end
		if (event_read) begin
			next_state.event_bits = '0; // [R4]
		end
		// A capture in the read cycle survives the clear
		next_state.event_bits = next_state.event_bits
			| (condition & state.enable & VALID_MASK); // [R3] [R5]
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign enable = state.enable;
	assign event_bits = state.event_bits;

endmodule

`default_nettype wire

// *** status_checker_props.sv ***
// Port checks for the status register groups
`timescale 1ns/10ps
`default_nettype none
module status_checker (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Watchdog
	input wire logic link_watchdog_expired,
	input wire logic watchdog_enabled,
	input wire logic protection_clear,
	input wire logic output_shutdown,
	// Event sources
	input wire logic command_finished,
	input wire logic error_valid,
	input wire logic signed [15:0] error_code,
	// Host access
	input wire logic cmd_read,
	input wire logic [2:0] cmd_sel,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Read answers: exactly one cycle later, never unasked
	property p_answer; cmd_read |=> rd_valid; endproperty
	a_answer: assert property (p_answer) else $error("read not answered");
	property p_no_stray; !cmd_read |=> !rd_valid; endproperty
	a_no_stray: assert property (p_no_stray) else $error("stray answer");
	// Fault bit 15 mirrors the watchdog fault
	property p_bit15; cmd_read && cmd_sel == 3'h0 |=> rd_data[15] == $past(output_shutdown); endproperty
	a_bit15: assert property (p_bit15) else $error("fault bit 15 wrong");
	// Spare positions read zero
	property p_spare; cmd_read && cmd_sel <= 3'h2 |=> !rd_data[0]; endproperty
	a_spare: assert property (p_spare) else $error("fault bit 0 set");
	property p_std; cmd_read && cmd_sel >= 3'h6 |=> rd_data[15:8] == 8'h00 && !rd_data[6] && !rd_data[1];
	endproperty
	a_std: assert property (p_std) else $error("std spare bit set");
	// Events seen by the very next status read
	property p_done; command_finished ##1 (cmd_read && cmd_sel == 3'h6) |=> rd_data[0]; endproperty
	a_done: assert property (p_done) else $error("done bit missing");
	property p_cmd_err; error_valid && error_code inside {[-199:-100]} ##1 (cmd_read && cmd_sel == 3'h6)
		|=> rd_data[5]; endproperty
	a_cmd_err: assert property (p_cmd_err) else $error("command error missing");
	property p_qry_err; error_valid && error_code inside {[-499:-400]} ##1 (cmd_read && cmd_sel == 3'h6)
		|=> rd_data[2]; endproperty
	a_qry_err: assert property (p_qry_err) else $error("query error missing");
	// Expiry shuts down and stays until cleared
	property p_wd_set; link_watchdog_expired && watchdog_enabled |=> output_shutdown; endproperty
	a_wd_set: assert property (p_wd_set) else $error("no shutdown");
	property p_wd_hold; output_shutdown && watchdog_enabled && !protection_clear |=> output_shutdown;
	endproperty
	a_wd_hold: assert property (p_wd_hold) else $error("shutdown dropped");
endmodule
bind status_event_register_groups status_checker i_status_checker (.clock, .rst_n,
	.link_watchdog_expired, .watchdog_enabled, .protection_clear, .output_shutdown,
	.command_finished, .error_valid, .error_code, .cmd_read, .cmd_sel, .rd_data, .rd_valid);
`default_nettype wire

// *** host_model.sv ***
// Host side issuing register commands
`timescale 1ns/10ps
`default_nettype none
module host_model (
	// Clock
	input wire logic clock,
	// Commands toward the block
	output logic cmd_write,
	output logic cmd_read,
	output logic [2:0] cmd_sel,
	output logic [15:0] cmd_wdata
);
	initial begin
		cmd_write = 1'h0;
		cmd_read = 1'h0;
		cmd_sel = 3'h0;
		cmd_wdata = 16'h0000;
	end
	// One request per falling edge, taken at the next rising edge
	task automatic access(input logic w, input logic [2:0] sel, input logic [15:0] data);
		@(negedge clock);
		cmd_write <= w;
		cmd_read <= !w;
		cmd_sel <= sel;
		cmd_wdata <= w ? data : ~cmd_wdata;
	endtask
	// Idle gaps; data toggles so a stale word never looks valid
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clock);
			cmd_write <= 1'h0;
			cmd_read <= 1'h0;
			cmd_wdata <= ~cmd_wdata;
		end
	endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the status register groups
`timescale 1ns/10ps
`default_nettype none
`define CHECK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
	$display("MISMATCH t=%0t got %h want %h", $time, a, b); end end
module testbench;
	logic clock = 1'h0, rst_n, link_watchdog_expired, watchdog_enabled;
	logic protection_clear, command_finished, error_valid;
	logic power_on_clear_flag, output_shutdown, rd_valid, cmd_write, cmd_read;
	logic signed [15:0] error_code;
	logic [7:0] saved_standard_enable;
	logic [14:1] fp;
	logic [15:0] op, rd_data, cmd_wdata, m, p;
	logic [2:0] cmd_sel;
	logic [31:0] seed = 32'h0000c5c3, r;
	logic [15:0] expq[$];
	int num_errors = 0, samples_checked = 0, cycles = 0;
	logic signed [15:0] codes [15] = '{-16'sd100, -16'sd199, -16'sd200, -16'sd299, -16'sd300,
		-16'sd399, 16'sd1, 16'sd32762, -16'sd400, -16'sd499, -16'sd99, -16'sd500, 16'sd32763, 16'sd0, -16'sd1};
	logic [7:0] bits [15] = '{8'h20, 8'h20, 8'h10, 8'h10, 8'h08, 8'h08, 8'h08, 8'h08, 8'h04, 8'h04,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	status_event_register_groups i_status_event_register_groups (.clock, .rst_n,
		.mains_fail(fp[1]), .over_temperature(fp[2]), .foldback_fault(fp[3]), .overvoltage_fault(fp[4]),
		.daisy_shutoff(fp[5]), .output_off(fp[6]), .interlock_fault(fp[7]), .external_enable_fault(fp[8]),
		.undervoltage_protect(fp[9]), .parallel_acknowledge(fp[10]), .general_fault(fp[11]),
		.parallel_fault(fp[12]), .parallel_wait_for_follower(fp[13]), .power_switch_off_fault(fp[14]),
		.voltage_regulation_mode(op[0]), .current_regulation_mode(op[1]), .no_fault_flag(op[2]),
		.trigger_wait_flag(op[3]), .auto_power_up_flag(op[4]), .foldback_armed(op[5]),
		.sequencer_step_flag(op[6]), .front_panel_control_flag(op[7]), .undervoltage_protect_armed(op[8]),
		.interlock_control_active(op[9]), .enable_control_active(op[10]), .current_foldback_armed(op[11]),
		.external_voltage_ref(op[12]), .external_current_ref(op[13]), .power_limit_armed(op[14]),
		.power_regulation_mode(op[15]), .link_watchdog_expired, .watchdog_enabled, .protection_clear,
		.output_shutdown, .command_finished, .error_valid, .error_code, .power_on_clear_flag,
		.saved_standard_enable, .cmd_write, .cmd_read, .cmd_sel, .cmd_wdata, .rd_data, .rd_valid);
	host_model i_host_model (.clock, .cmd_write, .cmd_read, .cmd_sel, .cmd_wdata);
	always #4 clock = ~clock;
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	// Answer monitor takes the oldest note
	always @(negedge clock) begin
		if (rd_valid === 1'h1) begin
			if (expq.size() == 0) begin
				num_errors++;
				$display("MISMATCH t=%0t unexpected answer", $time);
			end else begin
				m = expq.pop_front();
				`CHECK(rd_data, m)
			end
		end
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic rd(input logic [2:0] sel, input logic [15:0] want);
		expq.push_back(want);
		i_host_model.access(1'h0, sel, 16'h0000);
	endtask
	// Drop any pending strobe first, or it would be taken again after release
	task automatic do_reset();
		i_host_model.idle(1);
		rst_n = 1'h0;
		repeat (10) @(negedge clock);
		rst_n = 1'h1;
		repeat (3) @(negedge clock);
	endtask
	// One-cycle event pulse, status read at the very next edge
	task automatic pulse(input logic done, input logic signed [15:0] code, input logic [15:0] want);
		i_host_model.idle(1);
		command_finished = done;
		error_valid = !done;
		error_code = code;
		expq.push_back(want);
		i_host_model.access(1'h0, 3'h6, 16'h0000);
		command_finished = 1'h0;
		error_valid = 1'h0;
		error_code = ~code;
	endtask
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		// Quiet inputs, random stored enable; power up keeps it, spares masked
		rst_n = 1'h0;
		link_watchdog_expired = 1'h0;
		watchdog_enabled = 1'h0;
		protection_clear = 1'h0;
		command_finished = 1'h0;
		error_valid = 1'h0;
		error_code = 16'sh0000;
		power_on_clear_flag = 1'h0;
		fp = '0;
		op = '0;
		r = xs();
		saved_standard_enable = r[7:0];
		do_reset();
		rd(3'h6, 16'h0080);
		rd(3'h6, 16'h0000);
		rd(3'h7, {8'h00, saved_standard_enable & 8'hbd});
		power_on_clear_flag = 1'h1;
		do_reset();
		rd(3'h7, 16'h0000);
		rd(3'h6, 16'h0080);
		for (int s = 1; s < 6; s++)
			if (s != 3)
				rd(s[2:0], 16'h0000);
		i_host_model.access(1'h1, 3'h7, 16'hffff);
		i_host_model.access(1'h1, 3'h0, 16'hffff);
		rd(3'h7, 16'h00bd);
		$display("test reset_values done");
		// Random pin patterns through both condition registers
		for (int i = 0; i < 8; i++) begin
			i_host_model.idle(1);
			r = xs();
			fp = r[13:0];
			op = r[31:16];
			i_host_model.idle(3);
			rd(3'h0, {2'h0, r[13:0]} << 1);
			rd(3'h3, r[31:16]);
		end
		$display("test conditions done");
		// Masked capture, repeated toggles, read clears
		for (int i = 0; i < 6; i++) begin
			i_host_model.idle(1);
			fp = '0;
			op = '0;
			r = xs();
			i_host_model.access(1'h1, 3'h2, r[15:0]);
			i_host_model.access(1'h1, 3'h5, ~r[15:0]);
			repeat (3) begin
				i_host_model.idle(1);
				fp = r[30:17];
				op = r[31:16];
				i_host_model.idle(3);
				fp = '0;
				op = '0;
				i_host_model.idle(3);
			end
			rd(3'h1, r[31:16] & r[15:0] & 16'h7ffe);
			rd(3'h4, r[31:16] & ~r[15:0]);
			rd(3'h1, 16'h0000);
			rd(3'h4, 16'h0000);
			rd(3'h2, r[15:0] & 16'hfffe);
		end
		$display("test events done");
		// Every error range edge, then completion
		for (int i = 0; i < 15; i++)
			pulse(1'h0, codes[i], {8'h00, bits[i]});
		pulse(1'h1, 16'sh0000, 16'h0001);
		$display("test std_events done");
		// Watchdog: ignored when off, sets fault, cleared two ways
		link_watchdog_expired = 1'h1;
		i_host_model.idle(3);
		`CHECK(output_shutdown, 1'h0)
		watchdog_enabled = 1'h1;
		i_host_model.idle(1);
		link_watchdog_expired = 1'h0;
		i_host_model.idle(3);
		`CHECK(output_shutdown, 1'h1)
		rd(3'h0, 16'h8000);
		protection_clear = 1'h1;
		i_host_model.idle(1);
		protection_clear = 1'h0;
		rd(3'h0, 16'h0000);
		link_watchdog_expired = 1'h1;
		i_host_model.idle(1);
		link_watchdog_expired = 1'h0;
		watchdog_enabled = 1'h0;
		i_host_model.idle(3);
		`CHECK(output_shutdown, 1'h0)
		$display("test watchdog done");
		i_host_model.idle(4);
		// Every read must have been answered
		`CHECK(expq.size(), 0)
		tally_and_finish();
	end
endmodule
`default_nettype wire
